// ==== hdl/smc_top.sv ====
// sleep mode controller with avalon-mm register slave
// Notes on behaviour
// R1 - active mode plus idle, standby and deepest sleep, each entered from active.
// R2 - software picks mode and sets enable; sleep starts only on the sleep instruction.
// R3 - wake interrupt ends sleep; cpu runs handler then continues after sleep.
// R4 - any reset during sleep ends it and restarts from the reset vector.
// R5 - registers and memory keep their contents in every sleep mode.
// R6 - idle stops only cpu clock; every interrupt source can wake.
// R7 - standby keeps rtc, logic, converters, timers, main osc only with run bits.
// R8 - deepest sleep keeps only brownout, watchdog, periodic timer and their oscillators.
// R9 - deepest sleep wakes on pin, periodic timer, level monitor, address match, logic.
// R10 - standby wake sources: fixed three, others only with run-in-standby set.
// R11 - in deepest sleep custom logic wakes only when it needs no clock.
// R12 - wake takes six peripheral cycles plus oscillator start; idle adds none.
// R13 - standby wake adds oscillator start only when main clock was stopped.
// R14 - deepest sleep stops main clock so wake adds oscillator start-up.
// R15 - brownout fuse code 0x3 holds execution until the detector is ready.
// R16 - with no enabled interrupt the device sleeps until reset.
// R17 - software enables wake interrupts and global interrupts before sleeping.
// R18 - mode codes: idle 0x0, standby 0x1, deepest 0x2; others reserved.
// R19 - a debug break wakes the device to active even with no interrupt.
// R20 - sleep instruction with enable clear does nothing; cpu continues.
`timescale 1ns/10ps
module smc_top
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// cpu side
	input wire logic sleep_instr,
	input wire logic debug_break,
	output logic cpu_resume,
	output logic sleeping,
	// wake sources, already masked by their interrupt enables
	input wire logic [smc_pkg::WS_N-1:0] wake_src,
	// oscillator and brownout status
	input wire logic main_osc_ready,
	input wire logic bod_ready,
	input wire logic [1:0] bod_active_fuse,
	// clock and domain gating
	output smc_pkg::smc_gate_t gate
);
	smc_pkg::smc_state_t state_reg, state_next;
	logic [7:0] ctrl_reg;
	logic [7:0] cfg_reg;
	logic [1:0] mode_reg;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic rd_pend_reg;
	logic [31:0] rdata_reg;
	logic [1:0] resp_reg;
	logic resume_reg;
	smc_pkg::smc_gate_t gate_reg, gate_next;

	// register decode
	wire hit_ctrl = (avs_address == smc_pkg::ADDR_CTRL);
	wire hit_cfg = (avs_address == smc_pkg::ADDR_STANDBY_CFG);
	wire hit_stat = (avs_address == smc_pkg::ADDR_STATUS);
	wire hit_any = hit_ctrl | hit_cfg | hit_stat;
	wire wr_ctrl = avs_write & hit_ctrl & avs_byteenable[0];
	wire wr_cfg = avs_write & hit_cfg & avs_byteenable[0];
	wire sleep_en = ctrl_reg[smc_pkg::CTRL_ENABLE_BIT];
	wire [1:0] sel_mode = ctrl_reg[smc_pkg::CTRL_MODE_LSB +: 2];
	wire mode_ok = (sel_mode != 2'h3); // [R18]
	wire [2:0] state_code = (state_reg == smc_pkg::ST_ACTIVE) ? 3'h0 :
		(state_reg == smc_pkg::ST_ASLEEP) ? 3'h1 :
		(state_reg == smc_pkg::ST_OSC_WAIT) ? 3'h2 :
		(state_reg == smc_pkg::ST_WAKE_COUNT) ? 3'h3 : 3'h4;
	wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_reg} :
		hit_cfg ? {24'h0, cfg_reg} :
		hit_stat ? {27'h0, state_code, mode_reg} : 32'h0;

	// reads answer one cycle after the request; writes complete at once
	assign avs_waitrequest = avs_read & ~rd_pend_reg;
	assign avs_readdata = rdata_reg;
	assign avs_response = resp_reg;

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			rd_pend_reg <= 1'b0;
			rdata_reg <= 32'h0;
			resp_reg <= 2'h0;
		end
		else
		begin
			rd_pend_reg <= avs_read & ~rd_pend_reg;
			if (avs_read & ~rd_pend_reg)
				rdata_reg <= rd_mux;
			if ((avs_read & ~rd_pend_reg) | avs_write)
				resp_reg <= hit_any ? 2'h0 : 2'h2;
		end
	end

	// registers keep their value across sleep; only reset clears them
	always_ff @(posedge core_clk)
	begin
		if (!rstn) // [R4]
		begin
			ctrl_reg <= smc_pkg::CTRL_RESET;
			cfg_reg <= smc_pkg::CFG_RESET;
		end
		else
		begin
			if (wr_ctrl) // [R5]
				ctrl_reg <= {5'h0, avs_writedata[2:0]};
			if (wr_cfg)
				cfg_reg <= avs_writedata[7:0];
		end
	end

	wire wake;
	smc_wake_filter u_filter
	(
		.mode(mode_reg),
		.stby_cfg(cfg_reg),
		.src(wake_src),
		.wake(wake)
	);

	// main osc stopped in standby unless kept by its run bit
	wire osc_was_off = (mode_reg == smc_pkg::MODE_DEEPEST)
		| ((mode_reg == smc_pkg::MODE_STANDBY) & ~cfg_reg[smc_pkg::CFG_MAINOSC_BIT]);
	wire bod_hold = (bod_active_fuse == smc_pkg::BOD_WAIT_CODE) & ~bod_ready;
	wire go_sleep = sleep_instr & sleep_en & mode_ok; // [R2]

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			smc_pkg::ST_ACTIVE:
			begin
				if (go_sleep) // [R20]
					state_next = smc_pkg::ST_ASLEEP;
			end
			smc_pkg::ST_ASLEEP:
			begin
				// no wake source and no debug break keeps this state until reset [R16]
				if (wake | debug_break) // [R19]
				begin
					cnt_next = smc_pkg::WAKE_CNT;
					if (osc_was_off) // [R13] [R14]
						state_next = smc_pkg::ST_OSC_WAIT;
					else
						state_next = smc_pkg::ST_WAKE_COUNT; // [R12]
				end
			end
			smc_pkg::ST_OSC_WAIT:
			begin
				if (main_osc_ready)
					state_next = smc_pkg::ST_WAKE_COUNT;
			end
			smc_pkg::ST_WAKE_COUNT:
			begin
				cnt_next = cnt_reg - 4'h1;
				if (cnt_reg == 4'h1) // [R12]
					state_next = smc_pkg::ST_BOD_WAIT;
			end
			smc_pkg::ST_BOD_WAIT:
			begin
				if (!bod_hold) // [R15]
					state_next = smc_pkg::ST_ACTIVE;
			end
			default:
				state_next = smc_pkg::ST_ACTIVE;
		endcase
	end

	// gating per mode; the sleep state holds the entered mode's view
	wire [1:0] gm = (state_reg == smc_pkg::ST_ACTIVE) ? sel_mode : mode_reg;
	wire in_sleep_next = (state_next == smc_pkg::ST_ASLEEP) | (state_next == smc_pkg::ST_OSC_WAIT);
	wire run_cpu = (state_next == smc_pkg::ST_ACTIVE);
	wire g_idle = (gm == smc_pkg::MODE_IDLE);
	wire g_stby = (gm == smc_pkg::MODE_STANDBY);
	wire osc_wake = (state_next == smc_pkg::ST_WAKE_COUNT) | (state_next == smc_pkg::ST_BOD_WAIT);

	// a domain runs when awake, in idle, or in standby with its run bit set
	function automatic logic keep_run(input logic asleep, input logic idle, input logic stby,
		input logic run_bit);
		keep_run = ~asleep | idle | (stby & run_bit);
	endfunction

	always_comb
	begin
		gate_next.cpu_clk_en = run_cpu; // [R6]
		gate_next.per_clk_en = ~in_sleep_next | g_idle;
		gate_next.rtc_en = keep_run(in_sleep_next, g_idle, g_stby,
			cfg_reg[smc_pkg::CFG_RTC_BIT]); // [R7]
		gate_next.logic_en = keep_run(in_sleep_next, g_idle, g_stby,
			cfg_reg[smc_pkg::CFG_LOGIC_BIT]);
		gate_next.adc_en = keep_run(in_sleep_next, g_idle, g_stby,
			cfg_reg[smc_pkg::CFG_ADC_BIT]);
		gate_next.timer_en = keep_run(in_sleep_next, g_idle, g_stby,
			cfg_reg[smc_pkg::CFG_TIMER_BIT]);
		gate_next.main_osc_en = ~in_sleep_next | g_idle | osc_wake
			| (state_next == smc_pkg::ST_OSC_WAIT)
			| (g_stby & cfg_reg[smc_pkg::CFG_MAINOSC_BIT]);
		gate_next.pit_osc_en = 1'b1; // [R8]
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state_reg <= smc_pkg::ST_ACTIVE;
			cnt_reg <= 4'h0;
			mode_reg <= smc_pkg::MODE_IDLE;
			gate_reg <= '1;
			resume_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (state_reg == smc_pkg::ST_ACTIVE && go_sleep) // [R1]
				mode_reg <= sel_mode;
			gate_reg <= gate_next;
			// one pulse when execution resumes after sleep [R3]
			resume_reg <= (state_reg == smc_pkg::ST_BOD_WAIT) && (state_next == smc_pkg::ST_ACTIVE);
		end
	end

	assign gate = gate_reg;
	assign cpu_resume = resume_reg;
	assign sleeping = ~gate_reg.cpu_clk_en;

	// checks
	sequence s_enter;
		state_reg == smc_pkg::ST_ACTIVE && go_sleep;
	endsequence
	sequence s_count_done;
		state_reg == smc_pkg::ST_WAKE_COUNT && cnt_reg == 4'h1;
	endsequence
	sequence s_wake_start;
		state_reg == smc_pkg::ST_ASLEEP && (wake || debug_break);
	endsequence

	a_sleep_needs_enable: assert property (@(posedge core_clk) disable iff (!rstn) // [R20]
		state_reg == smc_pkg::ST_ACTIVE && sleep_instr && !sleep_en |=> state_reg == smc_pkg::ST_ACTIVE)
		else $error("sleep entered with enable clear");
	a_sleep_entry: assert property (@(posedge core_clk) disable iff (!rstn) // [R2]
		s_enter |=> state_reg == smc_pkg::ST_ASLEEP ##1 sleeping)
		else $error("sleep not entered");
	a_wake_six: assert property (@(posedge core_clk) disable iff (!rstn) // [R12]
		state_reg == smc_pkg::ST_ASLEEP ##1 state_reg == smc_pkg::ST_WAKE_COUNT
		|-> state_reg == smc_pkg::ST_WAKE_COUNT [*6] ##1 state_reg == smc_pkg::ST_BOD_WAIT)
		else $error("wake count not six cycles");
	a_bod_hold: assert property (@(posedge core_clk) disable iff (!rstn) // [R15]
		state_reg == smc_pkg::ST_BOD_WAIT && bod_hold |=> state_reg == smc_pkg::ST_BOD_WAIT)
		else $error("left wake before brownout ready");
	a_count_exit: assert property (@(posedge core_clk) disable iff (!rstn) // [R12]
		(s_count_done and !bod_hold) |=> ##1 state_reg == smc_pkg::ST_ACTIVE)
		else $error("wake did not finish");
	a_debug_wake: assert property (@(posedge core_clk) disable iff (!rstn) // [R19]
		state_reg == smc_pkg::ST_ASLEEP && debug_break |=> state_reg != smc_pkg::ST_ASLEEP)
		else $error("debug break did not wake");
	a_no_wake_stay: assert property (@(posedge core_clk) disable iff (!rstn) // [R16]
		state_reg == smc_pkg::ST_ASLEEP && !wake && !debug_break |=> state_reg == smc_pkg::ST_ASLEEP)
		else $error("woke with no source");
	a_osc_wait: assert property (@(posedge core_clk) disable iff (!rstn) // [R14]
		state_reg == smc_pkg::ST_ASLEEP && mode_reg == smc_pkg::MODE_DEEPEST && wake
		|=> state_reg == smc_pkg::ST_OSC_WAIT)
		else $error("deep wake skipped oscillator start");
	a_idle_per_clk: assert property (@(posedge core_clk) disable iff (!rstn) // [R6]
		state_reg == smc_pkg::ST_ASLEEP && mode_reg == smc_pkg::MODE_IDLE
		|-> gate_reg.per_clk_en && !gate_reg.cpu_clk_en)
		else $error("idle gating wrong");
	a_resume_pulse: assert property (@(posedge core_clk) disable iff (!rstn) // [R3]
		state_reg == smc_pkg::ST_BOD_WAIT && !bod_hold |=> cpu_resume ##1 !cpu_resume)
		else $error("resume pulse missing");
	a_reserved_refused: assert property (@(posedge core_clk) disable iff (!rstn) // [R18]
		state_reg == smc_pkg::ST_ACTIVE && sleep_instr && sel_mode == 2'h3
		|=> state_reg == smc_pkg::ST_ACTIVE)
		else $error("sleep entered with reserved mode");
	a_mode_capture: assert property (@(posedge core_clk) disable iff (!rstn) // [R1]
		s_enter |=> mode_reg == $past(sel_mode))
		else $error("entered mode not captured");
	a_regs_kept: assert property (@(posedge core_clk) disable iff (!rstn) // [R5]
		state_reg != smc_pkg::ST_ACTIVE && !wr_cfg && !wr_ctrl
		|=> $stable(cfg_reg) && $stable(ctrl_reg))
		else $error("register lost during sleep");
	a_idle_direct: assert property (@(posedge core_clk) disable iff (!rstn) // [R12]
		s_wake_start ##0 mode_reg == smc_pkg::MODE_IDLE
		|=> state_reg == smc_pkg::ST_WAKE_COUNT)
		else $error("idle wake waited for oscillator");
	a_stby_osc_off: assert property (@(posedge core_clk) disable iff (!rstn) // [R13]
		s_wake_start ##0 mode_reg == smc_pkg::MODE_STANDBY && !cfg_reg[smc_pkg::CFG_MAINOSC_BIT]
		|=> state_reg == smc_pkg::ST_OSC_WAIT)
		else $error("standby wake skipped oscillator start");
	a_stby_osc_kept: assert property (@(posedge core_clk) disable iff (!rstn) // [R13]
		s_wake_start ##0 mode_reg == smc_pkg::MODE_STANDBY && cfg_reg[smc_pkg::CFG_MAINOSC_BIT]
		|=> state_reg == smc_pkg::ST_WAKE_COUNT)
		else $error("standby wake waited for running oscillator");
	a_osc_hold: assert property (@(posedge core_clk) disable iff (!rstn) // [R14]
		state_reg == smc_pkg::ST_OSC_WAIT && !main_osc_ready
		|=> state_reg == smc_pkg::ST_OSC_WAIT)
		else $error("left oscillator wait early");
	a_osc_done: assert property (@(posedge core_clk) disable iff (!rstn) // [R12]
		state_reg == smc_pkg::ST_OSC_WAIT && main_osc_ready
		|=> state_reg == smc_pkg::ST_WAKE_COUNT && cnt_reg == smc_pkg::WAKE_CNT)
		else $error("wake count not started after oscillator");
	a_count_step: assert property (@(posedge core_clk) disable iff (!rstn) // [R12]
		state_reg == smc_pkg::ST_WAKE_COUNT && cnt_reg != 4'h1
		|=> state_reg == smc_pkg::ST_WAKE_COUNT && cnt_reg == $past(cnt_reg) - 4'h1)
		else $error("wake count skipped a cycle");
	a_bod_exit: assert property (@(posedge core_clk) disable iff (!rstn) // [R15]
		state_reg == smc_pkg::ST_BOD_WAIT && !bod_hold |=> state_reg == smc_pkg::ST_ACTIVE)
		else $error("stuck after brownout ready");
	a_deep_gates: assert property (@(posedge core_clk) disable iff (!rstn) // [R8]
		state_reg == smc_pkg::ST_ASLEEP && mode_reg == smc_pkg::MODE_DEEPEST
		|-> !gate_reg.per_clk_en && !gate_reg.main_osc_en
		&& !gate_reg.rtc_en && gate_reg.pit_osc_en)
		else $error("deepest sleep gating wrong");
	a_stby_rtc: assert property (@(posedge core_clk) disable iff (!rstn) // [R7]
		state_reg == smc_pkg::ST_ASLEEP && mode_reg == smc_pkg::MODE_STANDBY
		|-> gate_reg.rtc_en == $past(cfg_reg[smc_pkg::CFG_RTC_BIT]))
		else $error("standby rtc gating wrong");
	a_stby_main_osc: assert property (@(posedge core_clk) disable iff (!rstn) // [R7]
		state_reg == smc_pkg::ST_ASLEEP && mode_reg == smc_pkg::MODE_STANDBY
		|-> gate_reg.main_osc_en == $past(cfg_reg[smc_pkg::CFG_MAINOSC_BIT]))
		else $error("standby oscillator gating wrong");
	a_active_all_run: assert property (@(posedge core_clk) disable iff (!rstn) // [R1]
		state_reg == smc_pkg::ST_ACTIVE |-> gate_reg == 8'hff)
		else $error("domain gated in active mode");
	a_asleep_cpu_off: assert property (@(posedge core_clk) disable iff (!rstn) // [R3]
		state_reg != smc_pkg::ST_ACTIVE |-> sleeping)
		else $error("cpu clock running before wake done");
	a_resume_source: assert property (@(posedge core_clk) disable iff (!rstn) // [R3]
		cpu_resume
		|-> state_reg == smc_pkg::ST_ACTIVE && $past(state_reg) == smc_pkg::ST_BOD_WAIT)
		else $error("resume pulse without wake");
	a_deep_stays: assert property (@(posedge core_clk) disable iff (!rstn) // [R9]
		state_reg == smc_pkg::ST_ASLEEP && mode_reg == smc_pkg::MODE_DEEPEST && !debug_break
		&& !wake_src[smc_pkg::WS_PIN]
		&& !wake_src[smc_pkg::WS_ADDR]
		&& !wake_src[smc_pkg::WS_PIT]
		&& !wake_src[smc_pkg::WS_VLM]
		&& !(wake_src[smc_pkg::WS_LOGIC] && cfg_reg[smc_pkg::CFG_LOGIC_NOCLK_BIT])
		|=> state_reg == smc_pkg::ST_ASLEEP)
		else $error("deepest sleep woke on blocked source");
	a_idle_any: assert property (@(posedge core_clk) disable iff (!rstn) // [R6]
		state_reg == smc_pkg::ST_ASLEEP && mode_reg == smc_pkg::MODE_IDLE && (|wake_src)
		|=> state_reg != smc_pkg::ST_ASLEEP)
		else $error("idle did not wake on interrupt");
	a_write_lands: assert property (@(posedge core_clk) disable iff (!rstn) // [R2]
		wr_ctrl |=> ctrl_reg == {5'h0, $past(avs_writedata[2:0])})
		else $error("control write lost");
	a_read_answer: assert property (@(posedge core_clk) disable iff (!rstn) // [R5]
		avs_read && !rd_pend_reg |=> !avs_waitrequest && avs_readdata == $past(rd_mux))
		else $error("read answer wrong");
endmodule

// ==== hdl/smc_pkg.sv ====
// package: sleep controller constants, types and register layout
package smc_pkg;
	// mode select codes
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_STANDBY = 2'h1;
	localparam logic [1:0] MODE_DEEPEST = 2'h2;
	// register map (byte addresses, word aligned)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STANDBY_CFG = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	// control register fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// standby config fields
	localparam int CFG_RTC_BIT = 0;
	localparam int CFG_LOGIC_BIT = 1;
	localparam int CFG_ADC_BIT = 2;
	localparam int CFG_TIMER_BIT = 3;
	localparam int CFG_MAINOSC_BIT = 4;
	localparam int CFG_UART_BIT = 5;
	localparam int CFG_COMP_BIT = 6;
	localparam int CFG_LOGIC_NOCLK_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// brownout fuse code that holds execution for the detector
	localparam logic [1:0] BOD_WAIT_CODE = 2'h3;
	// wake-up base time, in peripheral clock cycles
	localparam int WAKE_CYCLES = 6;
	localparam logic [3:0] WAKE_CNT = 4'(WAKE_CYCLES);
	// wake source vector positions
	localparam int WS_PIN = 0;
	localparam int WS_ADDR = 1;
	localparam int WS_PIT = 2;
	localparam int WS_VLM = 3;
	localparam int WS_LOGIC = 4;
	localparam int WS_RTC = 5;
	localparam int WS_UART = 6;
	localparam int WS_TIMER = 7;
	localparam int WS_ADC = 8;
	localparam int WS_COMP = 9;
	localparam int WS_OTHER = 10;
	localparam int WS_N = 11;

	typedef enum {ST_ACTIVE, ST_ASLEEP, ST_OSC_WAIT, ST_WAKE_COUNT, ST_BOD_WAIT} smc_state_t;

	// clock and domain gating outputs
	typedef struct packed {
		logic cpu_clk_en;
		logic per_clk_en;
		logic rtc_en;
		logic logic_en;
		logic adc_en;
		logic timer_en;
		logic main_osc_en;
		logic pit_osc_en;
	} smc_gate_t;
endpackage

// ==== hdl/smc_wake_filter.sv ====
// wake source qualification per sleep mode
`timescale 1ns/10ps
module smc_wake_filter
(
	// configuration
	input wire logic [1:0] mode,
	input wire logic [7:0] stby_cfg,
	// sources
	input wire logic [smc_pkg::WS_N-1:0] src,
	// result
	output logic wake
);
	wire is_idle = (mode == smc_pkg::MODE_IDLE);
	wire is_stby = (mode == smc_pkg::MODE_STANDBY);
	wire is_deep = (mode == smc_pkg::MODE_DEEPEST);
	wire always_src = src[smc_pkg::WS_PIN] | src[smc_pkg::WS_ADDR] | src[smc_pkg::WS_PIT];
	// standby sources gated by their own run-in-standby bits
	wire stby_src = (src[smc_pkg::WS_LOGIC] & stby_cfg[smc_pkg::CFG_LOGIC_BIT])
		| (src[smc_pkg::WS_RTC] & stby_cfg[smc_pkg::CFG_RTC_BIT])
		| (src[smc_pkg::WS_UART] & stby_cfg[smc_pkg::CFG_UART_BIT])
		| (src[smc_pkg::WS_TIMER] & stby_cfg[smc_pkg::CFG_TIMER_BIT])
		| (src[smc_pkg::WS_ADC] & stby_cfg[smc_pkg::CFG_ADC_BIT])
		| (src[smc_pkg::WS_COMP] & stby_cfg[smc_pkg::CFG_COMP_BIT]);
	wire deep_src = src[smc_pkg::WS_VLM]
		| (src[smc_pkg::WS_LOGIC] & stby_cfg[smc_pkg::CFG_LOGIC_NOCLK_BIT]); // [R11]
	assign wake = (is_idle & (|src)) // [R6]
		| (is_stby & (always_src | stby_src)) // [R10]
		| (is_deep & (always_src | deep_src)); // [R9]
endmodule

// ==== test/smc_peer.sv ====
// oscillator and brownout readiness model
`timescale 1ns/10ps
module smc_peer
#(
	parameter int OSC_DLY = 8,
	parameter int BOD_DLY = 30
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// gating from the controller
	input wire smc_pkg::smc_gate_t gate,
	// readiness
	output logic main_osc_ready,
	output logic bod_ready
);
	int osc_n;
	assign main_osc_ready = osc_n >= OSC_DLY;
	assign bod_ready = osc_n >= BOD_DLY;
	// detector settles only after the oscillator restarts
	always @(posedge core_clk)
		if (!rstn)
			osc_n <= BOD_DLY;
		else if (!gate.main_osc_en)
			osc_n <= 0;
		else if (osc_n < BOD_DLY)
			osc_n <= osc_n + 1;
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the sleep controller
`timescale 1ns/10ps
module tb_top;
	localparam int OSC = 8;
	localparam int BROWNOUT_DETECTOR = 30;
	localparam logic [3:0] A_CTL = smc_pkg::ADDR_CTRL;
	localparam logic [3:0] A_CFG = smc_pkg::ADDR_STANDBY_CFG;
	logic core_clk = 0;
	logic rstn = 0;
	logic [3:0] adr = 0;
	logic rd_q = 0;
	logic wr_q = 0;
	logic [31:0] wd = 0;
	logic [31:0] rdata;
	logic wreq;
	logic [1:0] resp;
	logic slp = 0;
	logic dbg = 0;
	logic resume;
	logic sleeping;
	logic [10:0] src = 0;
	logic osc_rdy;
	logic bod_rdy;
	logic [1:0] fuse = 0;
	logic [3:0] be = 4'hf;
	smc_pkg::smc_gate_t gate;
	int bad_count = 0;
	int n_checks = 0;
	logic [31:0] r;
	int n;
	always #50 core_clk = ~core_clk;
	smc_top dut_u (.core_clk(core_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd_q),
		.avs_write(wr_q), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .avs_response(resp), .sleep_instr(slp), .debug_break(dbg),
		.cpu_resume(resume), .sleeping(sleeping), .wake_src(src), .main_osc_ready(osc_rdy),
		.bod_ready(bod_rdy), .bod_active_fuse(fuse), .gate(gate));
	smc_peer #(.OSC_DLY(OSC), .BOD_DLY(BROWNOUT_DETECTOR)) p_u (.core_clk(core_clk), .rstn(rstn),
		.gate(gate), .main_osc_ready(osc_rdy), .bod_ready(bod_rdy));
	task automatic stop_test;
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkr(input int got, input int lo, input int hi);
		chk(32'(got), (got >= lo && got <= hi) ? 32'(got) : 32'(lo));
	endtask
	task automatic tmo;
		bad_count++;
		stop_test();
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		int i;
		adr <= a;
		rd_q <= !w;
		wr_q <= w;
		wd <= d;
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (wreq !== 1'b0 && i < 50);
		r = rdata;
		if (i >= 50)
			tmo();
		rd_q <= 0;
		wr_q <= 0;
		@(posedge core_clk);
	endtask
	task automatic go(input logic [7:0] ctl, input logic exp);
		bus(A_CTL, 1, 32'(ctl));
		slp <= 1;
		@(posedge core_clk);
		slp <= 0;
		repeat (4) @(posedge core_clk);
		chk(sleeping, exp);
	endtask
	// source index WS_N stands for the debug break
	task automatic wake(input int b, input int lo, input int hi);
		if (b == smc_pkg::WS_N)
			dbg <= 1;
		else
			src[b] <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (resume !== 1'b1 && n < 300);
		chkr(n, lo, hi);
		chk(gate.cpu_clk_en, 1);
		if (n >= 300)
			tmo();
		src <= 0;
		dbg <= 0;
		@(posedge core_clk);
	endtask
	task automatic hold(input int b);
		src[b] <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk(sleeping, 1);
		src <= 0;
		@(posedge core_clk);
	endtask
	initial
	begin
		repeat (6) @(posedge core_clk);
		rstn <= 1;
		@(posedge core_clk);
		bus(A_CTL, 0, 0);
		chk(r, 0);
		chk(resp, 2'h0);
		bus(A_CFG, 0, 0);
		chk(r, 0);
		bus(A_CTL, 1, 32'hff);
		bus(A_CTL, 0, 0);
		chk(r, 32'h07);
		be <= 4'h0;
		bus(A_CTL, 1, 32'h00);
		be <= 4'hf;
		bus(A_CTL, 0, 0);
		chk(r, 32'h07);
		bus(4'hc, 1, 32'h5a);
		bus(4'hc, 0, 0);
		chk(r, 0);
		chk(resp, 2'h2);
		go(8'h00, 0);
		go(8'h07, 0);
		go(8'h01, 1);
		chk(gate, 8'h7f);
		wake(smc_pkg::WS_OTHER, 6, 14);
		go(8'h05, 1);
		chk(gate, 8'h01);
		bus(smc_pkg::ADDR_STATUS, 0, 0);
		chk(r, 32'h06);
		hold(smc_pkg::WS_OTHER);
		hold(smc_pkg::WS_RTC);
		hold(smc_pkg::WS_LOGIC);
		wake(smc_pkg::WS_N, 6, 40);
		go(8'h05, 1);
		wake(smc_pkg::WS_PIT, 6 + OSC, 14 + OSC);
		bus(A_CFG, 1, 32'h80);
		go(8'h05, 1);
		wake(smc_pkg::WS_LOGIC, 6 + OSC, 14 + OSC);
		bus(A_CFG, 1, 32'h00);
		go(8'h03, 1);
		chk({gate.rtc_en, gate.main_osc_en}, 0);
		hold(smc_pkg::WS_UART);
		wake(smc_pkg::WS_PIN, 6 + OSC, 14 + OSC);
		bus(A_CFG, 1, 32'h31);
		go(8'h03, 1);
		chk({gate.rtc_en, gate.main_osc_en}, 2'h3);
		wake(smc_pkg::WS_UART, 6, 14);
		bus(A_CFG, 0, 0);
		chk(r, 32'h31);
		fuse <= 2'h3;
		bus(A_CFG, 1, 32'h00);
		go(8'h05, 1);
		wake(smc_pkg::WS_ADDR, BROWNOUT_DETECTOR, BROWNOUT_DETECTOR + 12);
		fuse <= 2'h0;
		go(8'h01, 1);
		rstn <= 0;
		repeat (2) @(posedge core_clk);
		rstn <= 1;
		@(posedge core_clk);
		chk(sleeping, 0);
		chk(gate, 8'hff);
		bus(A_CTL, 0, 0);
		chk(r, 0);
		stop_test();
	end
endmodule
